// ===== clock_source_select_prescaler_defs.vh
/*
 * Constants of the clock source select and prescaler block: register
 * offsets, field positions, reset values and counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef CLOCK_SOURCE_SELECT_PRESCALER_DEFS_VH
`define CLOCK_SOURCE_SELECT_PRESCALER_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CSP_SYSTEM_CLOCK_CONTROL_REG 12'h000
`define CSP_SYSTEM_MISC_REG 12'h004
`define CSP_PRESCALER_CONTROL_REG 12'h008
`define CSP_LOW_DIVIDER_STATE_REG 12'h00c

// ****************************************************************
// system clock control fields
// ****************************************************************
`define CSP_CPU_SEL_BIT 0
`define CSP_RC_OSC_ENABLE_BIT 1
`define CSP_CRYSTAL_OSC_ENABLE_BIT 2
`define CSP_EXT_CLOCK_SELECT_BIT 3
`define CSP_CRYSTAL_WARMUP_FLAG_BIT 4
`define CSP_EXT_CLOCK_PRESENT_BIT 5

// ****************************************************************
// misc and prescaler fields
// ****************************************************************
`define CSP_CPU_CLOCK_OUT_EN_BIT 0
`define CSP_CRYSTAL_CLOCK_OUT_EN_BIT 1
`define CSP_FAST_DEBOUNCE_SELECT_BIT 2
`define CSP_RC_WAKE_ON_PIN_BIT 3
`define CSP_LOW_DIVIDER_CLEAR_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define CSP_CPU_SEL_RESET 1'b0
`define CSP_RC_OSC_ENABLE_RESET 1'b1
`define CSP_CRYSTAL_OSC_ENABLE_RESET 1'b0
`define CSP_EXT_CLOCK_SELECT_RESET 1'b0
`define CSP_CRYSTAL_WARMUP_FLAG_RESET 1'b1
`define CSP_MISC_RESET 4'h0

// ****************************************************************
// counts and taps
// ****************************************************************
`define CSP_EXT_DETECT_PULSES 3'h4
`define CSP_WARMUP_CYCLES 37268
`define CSP_HIGH_DIV_STAGES 8
`define CSP_LOW_DIV_STAGES 15
`define CSP_DEBOUNCE_SLOW_TAP 6
`define CSP_DEBOUNCE_FAST_TAP 1

`endif

// ===== clk_div_chain.v
/*
 * Binary dividing chain advanced by a one-cycle tick, with a clear that
 * acts on any sys_clk edge, tick or not, and an asynchronous sleep reset.
 * Assumes tick and clear are synchronous to sys_clk.
 */
`timescale 1ns/1ps

module clk_div_chain #(
    parameter STAGES = 8
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire sleepRst,
    input wire tick,
    input wire clear,
    output reg [STAGES-1:0] count,
    output wire [STAGES-1:0] risePulse
);

    // ****************************************************************
    // counter
    // ****************************************************************
    always @(posedge sys_clk or posedge sleepRst) begin
        if (sleepRst) begin
            count <= {STAGES{1'b0}};
        end else if (sys_rst || clear) begin
            count <= {STAGES{1'b0}};
        end else if (tick) begin
            count <= count + {{(STAGES-1){1'b0}}, 1'b1};
        end
    end

    // ****************************************************************
    // per-stage rising edges
    // ****************************************************************
    genvar k;
    generate
        for (k = 0; k < STAGES; k = k + 1) begin : stageRise
            if (k == 0) begin : first
                assign risePulse[k] = tick & ~clear & ~count[0];
            end else begin : rest
                assign risePulse[k] = tick & ~clear & ~count[k] & (&count[k-1:0]);
            end
        end
    endgenerate

endmodule

// ===== clk_glitchfree_mux.v
/*
 * Glitch-free selector of sampled clock levels. One enable per source;
 * the old source is dropped on its low phase before the new one is
 * taken on its low phase. An empty select holds the output low.
 * Assumes all source levels are synchronous samples on sys_clk.
 */
`timescale 1ns/1ps

module clk_glitchfree_mux #(
    parameter N = 3
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire [N-1:0] srcLevel,
    input wire [N-1:0] selOneHot,
    output reg clkOut,
    output wire [N-1:0] activeSrc
);

    reg [N-1:0] srcEn_r;
    reg [N-1:0] selSync_r;

    assign activeSrc = srcEn_r;

    // ****************************************************************
    // select capture and per-source enables
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : srcGate
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    selSync_r[i] <= 1'b0;
                    srcEn_r[i] <= 1'b0;
                end else begin
                    selSync_r[i] <= selOneHot[i];
                    if (srcEn_r[i] && !selSync_r[i] && !srcLevel[i]) begin
                        srcEn_r[i] <= 1'b0;
                    end else if (!srcEn_r[i] && selSync_r[i] && !srcLevel[i] &&
                        ((srcEn_r & ~({{(N-1){1'b0}}, 1'b1} << i)) == {N{1'b0}})) begin
                        srcEn_r[i] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            clkOut <= 1'b0;
        end else begin
            clkOut <= |(srcLevel & srcEn_r);
        end
    end

endmodule

// ===== clock_source_select_prescaler.v
/*
 * Clock source select and prescaler control: CPU clock selection among
 * RC, crystal and external clock, external clock detection, crystal
 * warm-up flag, high and low divider chains, debounce clock and clock
 * pin outputs, with control registers on APB.
 * Assumes oscillator levels and pins are sampled synchronously to sys_clk,
 * whose rate is well above every source clock.
 */
`timescale 1ns/1ps
`include "clock_source_select_prescaler_defs.vh"

module clock_source_select_prescaler #(
    parameter [15:0] WARMUP_CYCLES = `CSP_WARMUP_CYCLES,
    parameter HIGH_STAGES = `CSP_HIGH_DIV_STAGES,
    parameter LOW_STAGES = `CSP_LOW_DIV_STAGES
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire sleepRst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire rcClkIn,
    input wire xtalClkIn,
    input wire extClkIn,
    input wire portaPin0,
    input wire rcFreqRange,
    input wire [3:0] rcFreqCoarse,
    output wire cpuClk,
    output reg debounceClk,
    output reg portbPin2,
    output reg portbPin3,
    output wire rcOscEnable,
    output wire crystalOscEnable,
    output wire crystalWarmupFlag,
    output wire extClockPresent
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    reg cpuSel_r;
    reg rcOscEnable_r;
    reg crystalOscEnable_r;
    reg extClockSelect_r;
    reg rcWakeOnPin_r;
    reg fastDebounceSelect_r;
    reg crystalClockOutEn_r;
    reg cpuClockOutEn_r;
    reg crystalWarmupFlag_r;
    reg extClockPresent_r;
    reg [2:0] extPulseCount_r;
    reg [15:0] warmupCount_r;
    reg lowDividerClear_r;
    reg rcPrev_r;
    reg xtalPrev_r;
    reg extPrev_r;
    reg [31:0] readData;
    reg addrHit;
    reg [2:0] muxSel;

    wire ctrlRst;
    wire apbWrite;
    wire apbSetup;
    wire wrClock;
    wire wrMisc;
    wire wrPre;
    wire xtalEnableReq;
    wire xtalEnableSet;
    wire crystalUsable;
    wire rcRise;
    wire xtalRise;
    wire extRise;
    wire highTick;
    wire lowTick;
    wire [2:0] tapIdx;
    wire [HIGH_STAGES-1:0] highCount;
    wire [HIGH_STAGES-1:0] highRise;
    wire [LOW_STAGES-1:0] lowCount;
    wire [2:0] activeSrc;
    wire [2:0] srcLevel;
    wire [15:0] warmupLast;

    // ****************************************************************
    // tap decoder
    // ****************************************************************
    // the rc runs near 80 kHz times (1 + 9*range) times (1 + coarse);
    // ratio to 32 kHz is 2.5 times that product, held here as 5x/2
    function [2:0] tapDecode;
        input range;
        input [3:0] coarse;
        reg [9:0] ratio5;
        reg [7:0] mult;
        integer k;
        begin
            mult = (range ? 8'h0a : 8'h01) * ({4'h0, coarse} + 8'h01);
            ratio5 = {2'b00, mult} * 10'h005;
            tapDecode = 3'h7;
            for (k = 7; k >= 0; k = k - 1) begin
                if ({1'b0, ratio5} <= (11'h003 << (k + 1))) begin
                    tapDecode = k[2:0];
                end
            end
        end
    endfunction

    // ****************************************************************
    // apb slave
    // ****************************************************************
    assign ctrlRst = sys_rst | sleepRst;
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite;
    assign pready = 1'b1;
    assign wrClock = apbWrite && (paddr == `CSP_SYSTEM_CLOCK_CONTROL_REG);
    assign wrMisc = apbWrite && (paddr == `CSP_SYSTEM_MISC_REG);
    assign wrPre = apbWrite && (paddr == `CSP_PRESCALER_CONTROL_REG);

    always @* begin
        readData = 32'h0000_0000;
        addrHit = 1'b1;
        case (paddr)
            `CSP_SYSTEM_CLOCK_CONTROL_REG: begin
                readData[`CSP_CPU_SEL_BIT] = cpuSel_r;
                readData[`CSP_RC_OSC_ENABLE_BIT] = rcOscEnable_r;
                readData[`CSP_CRYSTAL_OSC_ENABLE_BIT] = crystalOscEnable_r;
                readData[`CSP_EXT_CLOCK_SELECT_BIT] = extClockSelect_r;
                readData[`CSP_CRYSTAL_WARMUP_FLAG_BIT] = crystalWarmupFlag_r;
                readData[`CSP_EXT_CLOCK_PRESENT_BIT] = extClockPresent_r;
            end
            `CSP_SYSTEM_MISC_REG: begin
                readData[`CSP_CPU_CLOCK_OUT_EN_BIT] = cpuClockOutEn_r;
                readData[`CSP_CRYSTAL_CLOCK_OUT_EN_BIT] = crystalClockOutEn_r;
                readData[`CSP_FAST_DEBOUNCE_SELECT_BIT] = fastDebounceSelect_r;
                readData[`CSP_RC_WAKE_ON_PIN_BIT] = rcWakeOnPin_r;
            end
            `CSP_PRESCALER_CONTROL_REG: begin
                readData = 32'h0000_0000;
            end
            `CSP_LOW_DIVIDER_STATE_REG: begin
                readData[LOW_STAGES-1:0] = lowCount;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    assign pslverr = psel & penable & ~addrHit;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (apbSetup && !pwrite) begin
            prdata <= readData;
        end
    end

    // ****************************************************************
    // system clock control register
    // ****************************************************************
    assign xtalEnableReq = wrClock & pwdata[`CSP_CRYSTAL_OSC_ENABLE_BIT];
    assign xtalEnableSet = xtalEnableReq & ~crystalOscEnable_r & ~extClockSelect_r &
        ~pwdata[`CSP_EXT_CLOCK_SELECT_BIT] & ~extClockPresent_r;

    always @(posedge sys_clk) begin
        if (ctrlRst) begin
            cpuSel_r <= `CSP_CPU_SEL_RESET;
            rcOscEnable_r <= `CSP_RC_OSC_ENABLE_RESET;
            crystalOscEnable_r <= `CSP_CRYSTAL_OSC_ENABLE_RESET;
            extClockSelect_r <= `CSP_EXT_CLOCK_SELECT_RESET;
        end else begin
            if (wrClock) begin
                cpuSel_r <= pwdata[`CSP_CPU_SEL_BIT];
                rcOscEnable_r <= pwdata[`CSP_RC_OSC_ENABLE_BIT];
                extClockSelect_r <= pwdata[`CSP_EXT_CLOCK_SELECT_BIT];
                if (!pwdata[`CSP_CRYSTAL_OSC_ENABLE_BIT]) begin
                    crystalOscEnable_r <= 1'b0;
                end else if (xtalEnableSet) begin
                    crystalOscEnable_r <= 1'b1;
                end
            end
            if (rcWakeOnPin_r && portaPin0) begin
                rcOscEnable_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // misc register
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (ctrlRst) begin
            {rcWakeOnPin_r, fastDebounceSelect_r, crystalClockOutEn_r, cpuClockOutEn_r} <=
                `CSP_MISC_RESET;
        end else if (wrMisc) begin
            rcWakeOnPin_r <= pwdata[`CSP_RC_WAKE_ON_PIN_BIT];
            fastDebounceSelect_r <= pwdata[`CSP_FAST_DEBOUNCE_SELECT_BIT];
            crystalClockOutEn_r <= pwdata[`CSP_CRYSTAL_CLOCK_OUT_EN_BIT];
            cpuClockOutEn_r <= pwdata[`CSP_CPU_CLOCK_OUT_EN_BIT];
        end
    end

    // ****************************************************************
    // low divider clear request
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (ctrlRst) begin
            lowDividerClear_r <= 1'b0;
        end else if (wrPre && pwdata[`CSP_LOW_DIVIDER_CLEAR_BIT]) begin
            lowDividerClear_r <= 1'b1;
        end else if (lowTick) begin
            lowDividerClear_r <= 1'b0;
        end
    end

    // ****************************************************************
    // source edge sampling
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            rcPrev_r <= 1'b0;
            xtalPrev_r <= 1'b0;
            extPrev_r <= 1'b0;
        end else begin
            rcPrev_r <= rcClkIn;
            xtalPrev_r <= xtalClkIn;
            extPrev_r <= extClkIn;
        end
    end

    assign rcRise = rcClkIn & ~rcPrev_r;
    assign xtalRise = xtalClkIn & ~xtalPrev_r;
    assign extRise = extClkIn & ~extPrev_r;

    // ****************************************************************
    // external clock detection
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (ctrlRst || !extClockSelect_r) begin
            extPulseCount_r <= 3'h0;
            extClockPresent_r <= 1'b0;
        end else if (extRise && !extClockPresent_r) begin
            extPulseCount_r <= extPulseCount_r + 3'h1;
            if (extPulseCount_r + 3'h1 == `CSP_EXT_DETECT_PULSES) begin
                extClockPresent_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // crystal warm-up
    // ****************************************************************
    assign warmupLast = WARMUP_CYCLES - 16'h0001;

    always @(posedge sys_clk) begin
        if (ctrlRst || !crystalOscEnable_r) begin
            warmupCount_r <= 16'h0000;
            crystalWarmupFlag_r <= `CSP_CRYSTAL_WARMUP_FLAG_RESET;
        end else if (crystalWarmupFlag_r && xtalRise) begin
            warmupCount_r <= warmupCount_r + 16'h0001;
            if (warmupCount_r == warmupLast) begin
                crystalWarmupFlag_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // cpu clock selection
    // ****************************************************************
    // crystal unusable with external
    assign crystalUsable = crystalOscEnable_r & ~extClockSelect_r & ~extClockPresent_r;
    assign srcLevel = {extClkIn & extClockPresent_r, xtalClkIn & crystalUsable,
        rcClkIn & rcOscEnable_r};

    always @* begin
        if (!cpuSel_r) begin
            muxSel = 3'b001;
        end else if (crystalUsable) begin
            muxSel = 3'b010;
        end else begin
            muxSel = 3'b100;
        end
    end

    clk_glitchfree_mux #(
        .N(3)
    ) cpuMux (
        .sys_clk(sys_clk),
        .sys_rst(ctrlRst),
        .srcLevel(srcLevel),
        .selOneHot(muxSel),
        .clkOut(cpuClk),
        .activeSrc(activeSrc)
    );

    // ****************************************************************
    // divider chains
    // ****************************************************************
    // rc only
    assign highTick = rcRise & rcOscEnable_r;
    assign tapIdx = tapDecode(rcFreqRange, rcFreqCoarse);
    assign lowTick = crystalUsable ? xtalRise : highRise[tapIdx];

    clk_div_chain #(
        .STAGES(HIGH_STAGES)
    ) highDiv (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sleepRst(sleepRst),
        .tick(highTick),
        .clear(1'b0),
        .count(highCount),
        .risePulse(highRise)
    );

    clk_div_chain #(
        .STAGES(LOW_STAGES)
    ) lowDiv (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sleepRst(sleepRst),
        .tick(lowTick),
        .clear((lowDividerClear_r & lowTick) | xtalEnableSet),
        .count(lowCount),
        .risePulse()
    );

    // ****************************************************************
    // clock outputs
    // ****************************************************************
    always @(posedge sys_clk) begin
        if (ctrlRst) begin
            debounceClk <= 1'b0;
            portbPin2 <= 1'b0;
            portbPin3 <= 1'b0;
        end else begin
            debounceClk <= fastDebounceSelect_r ? lowCount[`CSP_DEBOUNCE_FAST_TAP] :
                lowCount[`CSP_DEBOUNCE_SLOW_TAP];
            portbPin2 <= cpuClockOutEn_r & cpuClk;
            portbPin3 <= crystalClockOutEn_r & crystalUsable & xtalClkIn;
        end
    end

    assign rcOscEnable = rcOscEnable_r;
    assign crystalOscEnable = crystalOscEnable_r;
    assign crystalWarmupFlag = crystalWarmupFlag_r;
    assign extClockPresent = extClockPresent_r;

endmodule

// ===== csp_properties.sv
/* Port checker of the clock source select block.
   Assumes it is bound to the top design module. */
`timescale 1ns/1ps
module csp_properties #(
    parameter [15:0] WARMUP_CYCLES = 37268
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire sleepRst,
    input wire extClkIn,
    input wire xtalClkIn,
    input wire cpuClk,
    input wire portbPin2,
    input wire portbPin3,
    input wire rcOscEnable,
    input wire crystalOscEnable,
    input wire crystalWarmupFlag,
    input wire extClockPresent
);
    reg [2:0] extEdges_r;
    reg [15:0] xtalEdges_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ****************
    // source edge counts
    // ****************
    always @(posedge sys_clk) begin
        if (sys_rst || sleepRst || $fell(extClockPresent))
            extEdges_r <= 3'h0;
        else if ($rose(extClkIn) && extEdges_r != 3'h7)
            extEdges_r <= extEdges_r + 3'h1;
        if (!crystalOscEnable)
            xtalEdges_r <= 16'h0;
        else if ($rose(xtalClkIn))
            xtalEdges_r <= xtalEdges_r + 16'h1;
    end
    sequence allOff;
        (!rcOscEnable && !crystalOscEnable && !extClockPresent)[*8];
    endsequence
    present_count_a: assert property ($rose(extClockPresent) |-> extEdges_r >= 3'h4)
        else $error("ext present before four pulses");
    xtal_block_a: assert property (extClockPresent |=> !$rose(crystalOscEnable))
        else $error("crystal enabled while ext present");
    xtal_pin_a: assert property (!crystalOscEnable || extClockPresent |=> !portbPin3)
        else $error("crystal pin active without crystal");
    cpu_pin_a: assert property (portbPin2 |-> $past(cpuClk))
        else $error("cpu pin high without cpu clock");
    cpu_off_a: assert property (allOff |=> !cpuClk)
        else $error("cpu clock runs with all sources off");
    high_hold_a: assert property (disable iff (sys_rst || sleepRst) $rose(cpuClk) |=> cpuClk)
        else $error("short high pulse on cpu clock");
    low_hold_a: assert property (disable iff (sys_rst || sleepRst) $fell(cpuClk) |=> !cpuClk)
        else $error("short low pulse on cpu clock");
    sleep_init_a: assert property (sleepRst |=> rcOscEnable && !crystalOscEnable
        && crystalWarmupFlag && !extClockPresent) else $error("bad state after sleep");
    warmup_len_a: assert property ($fell(crystalWarmupFlag) |-> xtalEdges_r == WARMUP_CYCLES)
        else $error("warm-up length wrong");
endmodule
bind clock_source_select_prescaler csp_properties #(.WARMUP_CYCLES(WARMUP_CYCLES)) props (
    .sys_clk, .sys_rst, .sleepRst, .extClkIn, .xtalClkIn, .cpuClk, .portbPin2, .portbPin3,
    .rcOscEnable, .crystalOscEnable, .crystalWarmupFlag, .extClockPresent);

// ===== osc_model.sv
/* Oscillator and external clock model, levels sampled on sys_clk.
   Assumes rc and crystal enables come from the block and extOn from the bench; a stopped source rests low. */
`timescale 1ns/1ps
module osc_model (
    input wire sys_clk,
    input wire rcOn,
    input wire xtalOn,
    input wire extOn,
    output reg rcClk = 1'b0,
    output reg xtalClk = 1'b0,
    output reg ext_clock_present = 1'b0
);
    reg [2:0] phase_r = 3'h0;
    reg [2:0] extPhase_r = 3'h0;
    reg rcRun_r = 1'b0, xtalRun_r = 1'b0, extRun_r = 1'b0;
    // ****************
    // sources start and stop only at period end, so pulses stay whole
    // ****************
    always @(posedge sys_clk) begin
        phase_r <= phase_r + 3'h1;
        extPhase_r <= (extPhase_r == 3'h5) ? 3'h0 : extPhase_r + 3'h1;
        if (phase_r[1:0] == 2'h3) rcRun_r <= rcOn;
        if (phase_r == 3'h7) xtalRun_r <= xtalOn;
        if (extPhase_r == 3'h5) extRun_r <= extOn;
        rcClk <= rcRun_r & phase_r[1];
        xtalClk <= xtalRun_r & phase_r[2];
        ext_clock_present <= extRun_r & (extPhase_r > 3'h2);
    end
endmodule

// ===== tb.sv
/* Self-checking bench of the clock source select block.
   Assumes the design files and osc_model are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin nTests = nTests + 1; if ((a) !== (b)) begin \
    mismatches = mismatches + 1; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
`define WAITU(c) for (i = 0; i < 2000 && !(c); i = i + 1) @(posedge sys_clk);
module tb;
    reg sys_clk = 1'b0, sys_rst = 1'b1, sleepRst = 1'b0, psel = 1'b0, penable = 1'b0;
    reg pwrite = 1'b0, extOn = 1'b0, portaPin0 = 1'b0, err;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0, rdat;
    wire [31:0] prdata;
    wire pready, pslverr, rcClk, xtalClk, ext_clock_present, cpuClk, debounceClk, portbPin2, portbPin3;
    wire rcOscEnable, crystalOscEnable, crystalWarmupFlag, extClockPresent;
    integer mismatches = 0, nTests = 0, i;
    always #20 sys_clk = ~sys_clk;
    clock_source_select_prescaler #(.WARMUP_CYCLES(16'h8)) dut (.sys_clk, .sys_rst, .sleepRst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rcClkIn(rcClk), .xtalClkIn(xtalClk), .extClkIn(ext_clock_present), .portaPin0,
        .rcFreqRange(1'b0), .rcFreqCoarse(4'h0), .cpuClk, .debounceClk, .portbPin2, .portbPin3,
        .rcOscEnable, .crystalOscEnable, .crystalWarmupFlag, .extClockPresent);
    osc_model osc (.sys_clk, .rcOn(rcOscEnable), .xtalOn(crystalOscEnable), .extOn,
        .rcClk, .xtalClk, .ext_clock_present);
    // ****************
    // bus access and verdict
    // ****************
    task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
        begin
            @(posedge sys_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1) @(posedge sys_clk);
            rdat = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task giveVerdict;
        begin
            $display("comparisons %0d mismatches %0d", nTests, mismatches);
            if (mismatches == 0 && nTests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        mismatches = mismatches + 1;
        giveVerdict;
    end
    // ****************
    // tests
    // ****************
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rdat, 32'h12)
        apb(1'b0, 12'h010, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 12'h004, 32'h4);
        `WAITU(debounceClk === 1'b1)
        `CHK(debounceClk, 1'b1)
        `CHK(i < 100, 1'b1)
        $display("reset test done");
        apb(1'b1, 12'h000, 32'h0a);
        extOn <= 1'b1;
        `WAITU(extClockPresent === 1'b1)
        `CHK(extClockPresent, 1'b1)
        apb(1'b1, 12'h000, 32'h0b);
        apb(1'b1, 12'h000, 32'h0f);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rdat, 32'h3b)
        repeat (16) @(posedge sys_clk);
        `WAITU(cpuClk === 1'b0)
        `WAITU(cpuClk === 1'b1)
        // external pulses stand three cycles, rc pulses only two
        repeat (2) @(posedge sys_clk);
        `CHK(cpuClk, 1'b1)
        apb(1'b1, 12'h000, 32'h0a);
        apb(1'b1, 12'h000, 32'h02);
        extOn <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rdat, 32'h12)
        $display("external clock test done");
        apb(1'b1, 12'h000, 32'h06);
        `WAITU(crystalWarmupFlag === 1'b0)
        `CHK(crystalWarmupFlag, 1'b0)
        apb(1'b1, 12'h004, 32'h3);
        `WAITU(portbPin3 === 1'b1)
        `CHK(portbPin3, 1'b1)
        apb(1'b1, 12'h000, 32'h07);
        apb(1'b1, 12'h000, 32'h05);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rdat, 32'h05)
        `WAITU(portbPin2 === 1'b1)
        `CHK(portbPin2, 1'b1)
        $display("crystal test done");
        apb(1'b1, 12'h000, 32'h04);
        apb(1'b1, 12'h000, 32'h00);
        repeat (16) @(posedge sys_clk);
        `CHK(cpuClk, 1'b0)
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b1, 12'h004, 32'h8);
        portaPin0 <= 1'b1;
        `WAITU(rcOscEnable === 1'b1)
        `CHK(rcOscEnable, 1'b1)
        portaPin0 <= 1'b0;
        $display("off and wake test done");
        sleepRst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sleepRst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        `CHK(rdat, 32'h12)
        apb(1'b0, 12'h004, 32'h0);
        `CHK(rdat, 32'h0)
        $display("sleep test done");
        giveVerdict;
    end
endmodule
